// File: rtl/rsg_ctrl.sv
`default_nettype none
// Summary of operation
// - Flank select steers fine modulation target compares.
// - Single ramp dead-time modulation also moves on-time.
// - Async bit lets chosen fault drive output.
// - Complete-cycle finishes current cycle; ignored in auto-run.
// - Run bit starts generator, overrides auto-run.
// - Two identical input blocks, each own register.
// - Capture enable lets input event capture counter.
// - Source select uses low and high select bits.
// - Sources: pin, comparator, alternate A, alternate B.
// - Polarity picks falling/low or rising/high event.
// - Filter needs four equal samples before change.
// - Fault mode code: off, modes 1-9, mode 14.
// - Soft trigger captures; reads back capture source.
// - Enabled input events load counter into capture.
// - Capture read whole in one beat; high byte copied to temp.
// - Event enable raises interrupt on block events.
// - Enhanced enable interrupts after fifteenth cycle.
// - End-of-cycle enable interrupts at cycle completion.
// - Activity flags set on output toggles, W1C.
// - Event flags set on events, readable, W1C.
// - Ramp number recorded at latest event flag.
// - End-of-cycle flag sets at cycle end, W1C.
module rsg_ctrl #(
	parameter int CNT_W = 12,
	parameter int FINE_W = 4
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] in_pin,
	input wire logic [1:0] alt_a_pin,
	input wire logic [1:0] alt_b_pin,
	input wire logic [1:0] comp_in,
	input wire logic [CNT_W-1:0] gen_count,
	input wire logic cycle_end,
	input wire logic enh_cycle_end,
	input wire logic [1:0] ramp_num,
	input wire logic single_ramp,
	input wire logic slave_run_in,
	input wire logic [1:0] core_wave,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic gen_active,
	output logic [3:0] fm_target,
	output logic fm_on_time_shift,
	output logic [1:0] fault_active,
	output logic [1:0] retrig_event,
	output logic [7:0] fault_mode_pair,
	output logic irq
);
	import rsg_pkg::*;

	initial begin
		if (CNT_W < 1 || CNT_W > 14 || FINE_W != 4) begin
			$error("rsg_ctrl: unsupported CNT_W or FINE_W");
		end
	end

	// Software registers.
	logic [7:0] gen_ctrl_q;
	rsg_in_ctl_type in_ctl_q [2];
	logic [7:0] irq_mask_q;
	logic [7:0] irq_flags_q, irq_flags_d;
	logic [7:0] out_cfg_q;
	logic auto_run_slave_q, enh_flag_q, enh_flag_d;
	logic [CNT_W-1:0] capture_q;
	logic soft_capture_trigger_q;
	logic [7:0] temp_q;

	// Bus handshake state.
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// Write happens once both halves are held and no answer is pending.
	wire wr_fire = !awready_q && !wready_q && !bvalid_q;
	wire rd_fire = s_axi_arvalid && arready_q;
	wire lane0 = wr_fire && wstrb_q[0];
	wire lane1 = wr_fire && wstrb_q[1];

	// Address decoder shared by both channels.
	function automatic logic mapped(input logic [7:0] a);
		mapped = a inside {RSG_OFS_GEN_CTRL, RSG_OFS_IN_A_CTRL,
			RSG_OFS_IN_B_CTRL, RSG_OFS_CAPTURE, RSG_OFS_IRQ_MASK,
			RSG_OFS_IRQ_FLAGS, RSG_OFS_OUT_CFG, RSG_OFS_AUX,
			RSG_OFS_TEMP};
	endfunction

	wire wr_gen = lane0 && awaddr_q == RSG_OFS_GEN_CTRL;
	wire wr_in_a = lane0 && awaddr_q == RSG_OFS_IN_A_CTRL;
	wire wr_in_b = lane0 && awaddr_q == RSG_OFS_IN_B_CTRL;
	wire wr_mask = lane0 && awaddr_q == RSG_OFS_IRQ_MASK;
	wire wr_flags = lane0 && awaddr_q == RSG_OFS_IRQ_FLAGS;
	wire wr_ocfg = lane0 && awaddr_q == RSG_OFS_OUT_CFG;
	wire wr_aux0 = lane0 && awaddr_q == RSG_OFS_AUX;
	wire wr_aux1 = lane1 && awaddr_q == RSG_OFS_AUX;
	wire soft_trig = lane1 && awaddr_q == RSG_OFS_CAPTURE &&
		wdata_q[RSG_CAP_SOFT];

	// Write address and data channels are taken independently.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RSG_RESP_OKAY;
			awaddr_q <= RSG_RST_BYTE;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? RSG_RESP_OKAY : RSG_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Read mux; the capture word is taken whole in one beat.
	logic [31:0] rd_mux;
	wire [15:0] cap_word = {soft_capture_trigger_q,
		(15-CNT_W)'(0), capture_q};
	always_comb begin
		unique case (s_axi_araddr)
			RSG_OFS_GEN_CTRL: rd_mux = {24'h0, gen_ctrl_q};
			RSG_OFS_IN_A_CTRL: rd_mux = {24'h0, in_ctl_q[0]};
			RSG_OFS_IN_B_CTRL: rd_mux = {24'h0, in_ctl_q[1]};
			RSG_OFS_CAPTURE: rd_mux = {16'h0, cap_word};
			RSG_OFS_IRQ_MASK: rd_mux = {24'h0, irq_mask_q};
			RSG_OFS_IRQ_FLAGS: rd_mux = {24'h0, irq_flags_q};
			RSG_OFS_OUT_CFG: rd_mux = {24'h0, out_cfg_q};
			RSG_OFS_AUX: rd_mux = {23'h0, enh_flag_q, 7'h0,
				auto_run_slave_q};
			RSG_OFS_TEMP: rd_mux = {24'h0, temp_q};
			default: rd_mux = 32'h0;
		endcase
	end

	// Read channel; a capture read also parks the high byte in temp.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RSG_RESP_OKAY;
			temp_q <= RSG_RST_BYTE;
		end else if (ce) begin
			if (rd_fire) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= mapped(s_axi_araddr) ? RSG_RESP_OKAY :
					RSG_RESP_SLVERR;
				if (s_axi_araddr == RSG_OFS_CAPTURE) begin
					temp_q <= cap_word[15:8];
				end
			end else if (rvalid_q && s_axi_rready) begin
				arready_q <= 1'b1;
				rvalid_q <= 1'b0;
			end
		end
	end

	// Plain control registers.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			gen_ctrl_q <= RSG_RST_BYTE;
			in_ctl_q[0] <= RSG_RST_BYTE;
			in_ctl_q[1] <= RSG_RST_BYTE;
			irq_mask_q <= RSG_RST_BYTE;
			out_cfg_q <= RSG_RST_BYTE;
			auto_run_slave_q <= 1'b0;
		end else if (ce) begin
			if (wr_gen) gen_ctrl_q <= wdata_q[7:0];
			if (wr_in_a) in_ctl_q[0] <= wdata_q[7:0];
			if (wr_in_b) in_ctl_q[1] <= wdata_q[7:0];
			if (wr_mask) irq_mask_q <= wdata_q[7:0] & RSG_IM_USED;
			if (wr_ocfg) out_cfg_q <= wdata_q[7:0];
			if (wr_aux0) auto_run_slave_q <= wdata_q[RSG_AUX_AUTO_RUN];
		end
	end

	// Input blocks: sync, select, filter, polarity and edge detect.
	logic [1:0] evt;
	logic [1:0] lvl_hit;
	logic [1:0] cap_hit;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_in
			logic [3:0] s1_q, s2_q;
			logic [RSG_FILT_LEN-1:0] hist_q;
			logic filt_q, cond_q;
			wire sel_hi = (g == 0) ? out_cfg_q[RSG_OC_SEL_HI_A] :
				out_cfg_q[RSG_OC_SEL_HI_B];
			wire [1:0] sel = {sel_hi, in_ctl_q[g].input_select_lo};
			wire raw = s2_q[sel];
			wire [3:0] pins = {alt_b_pin[g], alt_a_pin[g], comp_in[g],
				in_pin[g]};
			wire cond_now = (filt_q == in_ctl_q[g].event_polarity);
			// First stage feeds only the second stage.
			always_ff @(posedge clock) begin
				if (!rstn) begin
					s1_q <= '0;
					s2_q <= '0;
					hist_q <= '0;
					filt_q <= 1'b0;
					cond_q <= 1'b0;
				end else if (ce) begin
					s1_q <= pins;
					s2_q <= s1_q;
					hist_q <= {hist_q[RSG_FILT_LEN-2:0], raw};
					if (!in_ctl_q[g].noise_filter_enable) begin
						filt_q <= raw;
					end else if (&hist_q) begin
						filt_q <= 1'b1;
					end else if (~|hist_q) begin
						filt_q <= 1'b0;
					end
					cond_q <= cond_now;
				end
			end
			// An event is the arrival of the chosen polarity.
			assign evt[g] = cond_now && !cond_q;
			assign lvl_hit[g] = cond_now &&
				in_ctl_q[g].fault_mode_code != RSG_MODE_OFF;
			assign cap_hit[g] = evt[g] && in_ctl_q[g].capture_enable;
		end
	endgenerate

	// Legal fault modes qualify events; any nonzero code still drives fault_active.
	function automatic logic mode_ok(input logic [3:0] m);
		mode_ok = (m != RSG_MODE_OFF && m <= RSG_MODE_LAST) ||
			m == RSG_MODE_14;
	endfunction
	wire [1:0] mode_live = {mode_ok(in_ctl_q[1].fault_mode_code),
		mode_ok(in_ctl_q[0].fault_mode_code)};
	wire [1:0] blk_event = (evt & mode_live) | cap_hit;

	// Capture register: hardware events or the software trigger.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			capture_q <= '0;
			soft_capture_trigger_q <= 1'b0;
		end else if (ce) begin
			if (soft_trig) begin
				capture_q <= gen_count;
				soft_capture_trigger_q <= 1'b1;
			end else if (|cap_hit) begin
				capture_q <= gen_count;
				soft_capture_trigger_q <= 1'b0;
			end
		end
	end

	// Run control with graceful stop at cycle end.
	logic run_prev_q, finishing_q, gen_active_q;
	wire run_bit = gen_ctrl_q[RSG_GC_RUN];
	wire run_fall = run_prev_q && !run_bit;
	wire finishing_d = (finishing_q || (run_fall &&
		gen_ctrl_q[RSG_GC_CCYC] && !auto_run_slave_q)) &&
		!cycle_end && !run_bit;
	wire active_d = run_bit || (auto_run_slave_q && slave_run_in) ||
		finishing_d;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			run_prev_q <= 1'b0;
			finishing_q <= 1'b0;
			gen_active_q <= 1'b0;
		end else if (ce) begin
			run_prev_q <= run_bit;
			finishing_q <= finishing_d;
			gen_active_q <= active_d;
		end
	end

	// Fine modulation targets; order is RB, RA, SB, SA.
	wire [1:0] fm_sel = {gen_ctrl_q[RSG_GC_FM_HI], gen_ctrl_q[RSG_GC_FM_LO]};
	wire [3:0] fm_d = {fm_sel == 2'h3, fm_sel[1], fm_sel == 2'h1,
		!fm_sel[1]};
	wire fm_shift_d = single_ramp && fm_sel[1];

	// Output stage: a live fault forces the side inactive at once when that side's async bit is set.
	wire [1:0] afo = {gen_ctrl_q[RSG_GC_AFO_B], gen_ctrl_q[RSG_GC_AFO_A]};
	wire [1:0] wave_d = core_wave & ~(afo & lvl_hit);
	logic [1:0] wave_q, flt_q, rtg_q;
	logic [3:0] fm_q;
	logic fm_shift_q;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wave_q <= '0;
			flt_q <= '0;
			rtg_q <= '0;
			fm_q <= '0;
			fm_shift_q <= 1'b0;
		end else if (ce) begin
			wave_q <= wave_d;
			flt_q <= lvl_hit;
			rtg_q <= evt & mode_live;
			fm_q <= fm_d;
			fm_shift_q <= fm_shift_d;
		end
	end

	// Sticky flags; a same-cycle set beats a software clear.
	wire [7:0] clr = wr_flags ? (wdata_q[7:0] & RSG_IF_W1C) : 8'h00;
	wire [1:0] toggled = wave_d ^ wave_q;
	always_comb begin
		irq_flags_d = irq_flags_q & ~clr;
		irq_flags_d[RSG_IF_ACT_A] = irq_flags_d[RSG_IF_ACT_A] | toggled[0];
		irq_flags_d[RSG_IF_ACT_B] = irq_flags_d[RSG_IF_ACT_B] | toggled[1];
		irq_flags_d[RSG_IF_EV_A] = irq_flags_d[RSG_IF_EV_A] | blk_event[0];
		irq_flags_d[RSG_IF_EV_B] = irq_flags_d[RSG_IF_EV_B] | blk_event[1];
		if (|blk_event) begin
			irq_flags_d[RSG_IF_RAMP_LO +: 2] = ramp_num;
		end
		irq_flags_d[RSG_IF_EOC] = irq_flags_d[RSG_IF_EOC] | cycle_end;
		enh_flag_d = (enh_flag_q && !(wr_aux1 &&
			wdata_q[RSG_AUX_ENH_FLAG])) || enh_cycle_end;
	end

	// Flag storage and the single masked interrupt line.
	logic irq_q;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_flags_q <= RSG_RST_BYTE;
			enh_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_flags_q <= irq_flags_d;
			enh_flag_q <= enh_flag_d;
			irq_q <= (irq_flags_d[RSG_IF_EV_A] && irq_mask_q[RSG_IM_EV_A]) ||
				(irq_flags_d[RSG_IF_EV_B] && irq_mask_q[RSG_IM_EV_B]) ||
				(enh_flag_d && irq_mask_q[RSG_IM_ENH]) ||
				(irq_flags_d[RSG_IF_EOC] && irq_mask_q[RSG_IM_EOC]);
		end
	end

	// Every output leaves from a flop.
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wave_out_a = wave_q[0];
	assign wave_out_b = wave_q[1];
	assign gen_active = gen_active_q;
	assign fm_target = fm_q;
	assign fm_on_time_shift = fm_shift_q;
	assign fault_active = flt_q;
	assign retrig_event = rtg_q;
	assign fault_mode_pair = {in_ctl_q[1].fault_mode_code,
		in_ctl_q[0].fault_mode_code};
	assign irq = irq_q;

	// Checks on the block's own behaviour.
	AST_FM_SEL: assert property (@(posedge clock) disable iff (!rstn)
		ce && fm_sel == 2'h0 |=> fm_target == 4'h1)
		else $error("flank select 00 did not target RB only");
	AST_FM_SHIFT: assert property (@(posedge clock) disable iff (!rstn)
		ce && single_ramp && fm_sel[1] |=> fm_on_time_shift)
		else $error("dead-time modulation did not flag on-time shift");
	AST_ASYNC_OUT: assert property (@(posedge clock) disable iff (!rstn)
		ce && afo[0] && lvl_hit[0] |=> !wave_out_a)
		else $error("fault did not force side A inactive");
	AST_RUN_START: assert property (@(posedge clock) disable iff (!rstn)
		ce && run_bit |=> gen_active)
		else $error("run bit did not start generator");
	AST_CCYC_HOLD: assert property (@(posedge clock) disable iff (!rstn)
		ce && finishing_q && !cycle_end && !run_bit |=> gen_active)
		else $error("generator halted before cycle end");
	AST_CAPTURE: assert property (@(posedge clock) disable iff (!rstn)
		ce && |cap_hit && !soft_trig |=> capture_q == $past(gen_count)
		&& !soft_capture_trigger_q)
		else $error("input event did not capture counter");
	AST_SOFT_CAP: assert property (@(posedge clock) disable iff (!rstn)
		ce && soft_trig |=> soft_capture_trigger_q)
		else $error("soft trigger source not recorded");
	AST_EV_IRQ: assert property (@(posedge clock) disable iff (!rstn)
		ce && blk_event[0] && irq_mask_q[RSG_IM_EV_A] |=> irq)
		else $error("event A did not raise interrupt");
	AST_SET_WINS: assert property (@(posedge clock) disable iff (!rstn)
		ce && cycle_end |=> irq_flags_q[RSG_IF_EOC])
		else $error("end of cycle flag lost to clear");
	AST_ACT_FLAG: assert property (@(posedge clock) disable iff (!rstn)
		ce && toggled[1] |=> irq_flags_q[RSG_IF_ACT_B])
		else $error("output B toggle not flagged");
	COV_CAPTURE: cover property (@(posedge clock) disable iff (!rstn)
		ce && |cap_hit);
	COV_GRACEFUL_STOP: cover property (@(posedge clock) disable iff (!rstn)
		finishing_q ##1 !gen_active);
	COV_FAULT_FORCE: cover property (@(posedge clock) disable iff (!rstn)
		ce && |(afo & lvl_hit & core_wave));
endmodule
`default_nettype wire

// File: rtl/rsg_pkg.sv
`default_nettype none
package rsg_pkg;
	// Byte addresses of the register map on the AXI4-Lite port.
	localparam logic [7:0] RSG_OFS_GEN_CTRL = 8'h00;
	localparam logic [7:0] RSG_OFS_IN_A_CTRL = 8'h04;
	localparam logic [7:0] RSG_OFS_IN_B_CTRL = 8'h08;
	localparam logic [7:0] RSG_OFS_CAPTURE = 8'h0C;
	localparam logic [7:0] RSG_OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] RSG_OFS_IRQ_FLAGS = 8'h14;
	localparam logic [7:0] RSG_OFS_OUT_CFG = 8'h18;
	localparam logic [7:0] RSG_OFS_AUX = 8'h1C;
	localparam logic [7:0] RSG_OFS_TEMP = 8'h20;
	// Generator control fields.
	localparam int RSG_GC_RUN = 0;
	localparam int RSG_GC_CCYC = 1;
	localparam int RSG_GC_FM_LO = 2;
	localparam int RSG_GC_AFO_A = 3;
	localparam int RSG_GC_AFO_B = 4;
	localparam int RSG_GC_FM_HI = 5;
	// Interrupt mask and flag fields.
	localparam int RSG_IM_EOC = 0;
	localparam int RSG_IM_ENH = 1;
	localparam int RSG_IM_EV_A = 3;
	localparam int RSG_IM_EV_B = 4;
	localparam int RSG_IF_EOC = 0;
	localparam int RSG_IF_RAMP_LO = 1;
	localparam int RSG_IF_EV_A = 3;
	localparam int RSG_IF_EV_B = 4;
	localparam int RSG_IF_ACT_A = 6;
	localparam int RSG_IF_ACT_B = 7;
	localparam logic [7:0] RSG_IF_W1C = 8'hD9;
	localparam logic [7:0] RSG_IM_USED = 8'h1B;
	// Output configuration and auxiliary fields.
	localparam int RSG_OC_SEL_HI_B = 6;
	localparam int RSG_OC_SEL_HI_A = 7;
	localparam int RSG_AUX_AUTO_RUN = 0;
	localparam int RSG_AUX_ENH_FLAG = 8;
	localparam int RSG_CAP_SOFT = 15;
	// Reset values and codes.
	localparam logic [7:0] RSG_RST_BYTE = 8'h00;
	localparam logic [3:0] RSG_MODE_OFF = 4'h0;
	localparam logic [3:0] RSG_MODE_LAST = 4'h9;
	localparam logic [3:0] RSG_MODE_14 = 4'hE;
	localparam logic [1:0] RSG_RESP_OKAY = 2'h0;
	localparam logic [1:0] RSG_RESP_SLVERR = 2'h2;
	localparam int RSG_FILT_LEN = 4;
	// Layout of one input block control register.
	typedef struct packed {
		logic capture_enable;
		logic input_select_lo;
		logic event_polarity;
		logic noise_filter_enable;
		logic [3:0] fault_mode_code;
	} rsg_in_ctl_type;
endpackage
`default_nettype wire

// File: tb/rsg_core_model.sv
`default_nettype none
module rsg_core_model #(
	parameter int PERIOD = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic run,
	output logic [11:0] count,
	output logic cycle_end,
	output logic enh_cycle_end,
	output logic [1:0] ramp_num,
	output logic [1:0] core_wave
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] LAST = 12'(PERIOD - 1);
	logic [11:0] cnt_q;
	logic [3:0] cyc_q;
	logic wrap;

	// The count freezes while stopped, so a capture taken then is predictable.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cnt_q <= 12'h000;
			cyc_q <= 4'h0;
		end else if (run) begin
			cnt_q <= wrap ? 12'h000 : cnt_q + 12'h001;
			if (wrap) cyc_q <= (cyc_q == 4'hE) ? 4'h0 : cyc_q + 4'h1;
		end
	end

	// One pulse per whole cycle; the ramps are the quarters of a cycle.
	assign wrap = run && cnt_q == LAST;
	assign count = cnt_q;
	assign cycle_end = wrap;
	assign enh_cycle_end = wrap && cyc_q == 4'hE;
	assign ramp_num = cnt_q[3:2];
	assign core_wave = {cnt_q[2], cnt_q[3]};
endmodule
`default_nettype wire

// File: tb/tb_rsg_ctrl.sv
`default_nettype none
module tb_rsg_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import rsg_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;}
		rsg_note_type;
	logic clock, rstn, single_ramp;
	logic [7:0] s_axi_awaddr, s_axi_araddr, fault_mode_pair;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, fm_target;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, wave_out_a, wave_out_b;
	logic gen_active, fm_on_time_shift, irq, cycle_end, enh_cycle_end;
	logic [1:0] s_axi_bresp, s_axi_rresp, in_pin, alt_a_pin, alt_b_pin;
	logic [1:0] comp_in, fault_active, ramp_num, core_wave;
	logic [11:0] gen_count;
	int errors, cmp_count;
	rsg_note_type notes[$];
	rsg_note_type nt;

	// Free-running system clock.
	always #25 clock = ~clock;

	rsg_core_model part (.clock, .rstn, .run(gen_active),
		.count(gen_count), .cycle_end, .enh_cycle_end, .ramp_num, .core_wave);

	rsg_ctrl dut (.clock, .rstn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_pin, .alt_a_pin,
		.alt_b_pin, .comp_in, .gen_count, .cycle_end, .enh_cycle_end,
		.ramp_num, .single_ramp, .slave_run_in(1'b0), .core_wave,
		.wave_out_a, .wave_out_b, .gen_active, .fm_target, .fm_on_time_shift,
		.fault_active, .retrig_event(), .fault_mode_pair, .irq);

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		errors++;
		$display("unexpected %s: expected answer, seen none", nm);
		finish_test();
	endtask

	// Write and address are offered together and dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		logic aw, w, b;
		logic [1:0] resp;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		resp = 2'h0;
		// Look mid-cycle, so the next rising edge is the handshake edge.
		for (n = 0; n < 40; n++) begin
			@(negedge clock);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clock);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 40) hang("bvalid");
		chk("bresp", 32'(e), 32'(resp));
	endtask

	// The expected answer is noted first; the monitor compares it.
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] e);
		int n;
		logic ar, r;
		@(posedge clock);
		notes.push_back('{d, m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			@(posedge clock);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 40) hang("rvalid");
	endtask

	task automatic idle(input logic v);
		in_pin <= {2{v}};
		comp_in <= {2{v}};
		alt_a_pin <= {2{v}};
		alt_b_pin <= {2{v}};
	endtask

	task automatic drive(input logic [1:0] s, input int b, input logic v);
		case (s)
			2'h0: in_pin[b] <= v;
			2'h1: comp_in[b] <= v;
			2'h2: alt_a_pin[b] <= v;
			default: alt_b_pin[b] <= v;
		endcase
	endtask

	// Every read answer is matched against the oldest noted expectation.
	// Sampled mid-cycle: the answer is settled and stands to the next edge.
	always @(negedge clock) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready && notes.size() > 0) begin
			nt = notes.pop_front();
			chk("rdata", nt.d & nt.m, s_axi_rdata & nt.m);
			chk("rresp", 32'(nt.r), 32'(s_axi_rresp));
		end
	end

	initial begin
		logic [3:0] legal [11];
		logic [3:0] fm_exp [4];
		logic [3:0] b4;
		int n, hi;
		logic p;
		clock = 1'b0;
		rstn <= 1'b0;
		single_ramp <= 1'b0;
		s_axi_awaddr <= 8'h00;
		s_axi_araddr <= 8'h00;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
		{s_axi_arvalid, s_axi_rready} <= 2'h0;
		idle(1'b1);
		n = $urandom(82);
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		// Reset values, then an unmapped place in both directions.
		rd(RSG_OFS_IN_A_CTRL, 32'h0, 32'hFF, RSG_RESP_OKAY);
		rd(RSG_OFS_IN_B_CTRL, 32'h0, 32'hFF, RSG_RESP_OKAY);
		rd(RSG_OFS_IRQ_FLAGS, 32'h0, 32'hFF, RSG_RESP_OKAY);
		rd(8'h40, 32'h0, 32'hFFFFFFFF, RSG_RESP_SLVERR);
		wr(8'h40, 32'hFF, RSG_RESP_SLVERR);
		// Each flank selection steers the fine modulation.
		single_ramp <= 1'b1;
		fm_exp = '{4'h1, 4'h3, 4'h4, 4'hC};
		for (n = 0; n < 4; n++) begin
			b4 = 4'(n);
			wr(RSG_OFS_GEN_CTRL, {26'h0, b4[1], 2'h0, b4[0], 2'h0}, 2'h0);
			repeat (2) @(posedge clock);
			@(negedge clock);
			chk("fm_target", 32'(fm_exp[n]), 32'(fm_target));
			chk("fm_shift", 32'(b4[1]), 32'(fm_on_time_shift));
		end
		@(posedge clock);
		single_ramp <= 1'b0;
		// Every legal mode code; the partner block gets a random one.
		legal = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
			4'h9, 4'hE};
		for (n = 0; n < 11; n++) begin
			b4 = legal[$urandom % 11];
			p = 1'($urandom);
			wr(RSG_OFS_IN_A_CTRL, {27'h0, p, legal[n]}, RSG_RESP_OKAY);
			wr(RSG_OFS_IN_B_CTRL, {28'h0, b4}, RSG_RESP_OKAY);
			rd(RSG_OFS_IN_A_CTRL, {27'h0, p, legal[n]}, 32'hFF, 2'h0);
			repeat (2) @(posedge clock);
			@(negedge clock);
			chk("modes", {24'h0, b4, legal[n]}, 32'(fault_mode_pair));
		end
		wr(RSG_OFS_IN_A_CTRL, 32'h0, RSG_RESP_OKAY);
		wr(RSG_OFS_IN_B_CTRL, 32'h0, RSG_RESP_OKAY);
		idle(1'b0);
		wr(RSG_OFS_IRQ_FLAGS, 32'hFF, RSG_RESP_OKAY);
		// Run, then a graceful stop that must finish the cycle.
		wr(RSG_OFS_IRQ_MASK, 32'h02, RSG_RESP_OKAY);
		wr(RSG_OFS_GEN_CTRL, 32'h03, RSG_RESP_OKAY);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("gen_active", 32'h1, 32'(gen_active));
		repeat (300) @(posedge clock);
		wr(RSG_OFS_GEN_CTRL, 32'h02, RSG_RESP_OKAY);
		@(negedge clock);
		for (n = 0; n < 40 && cycle_end !== 1'b1; n++) @(negedge clock);
		if (n == 40) hang("cycle_end");
		chk("gen_active", 32'h1, 32'(gen_active));
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("gen_active", 32'h0, 32'(gen_active));
		chk("irq", 32'h1, 32'(irq));
		wr(RSG_OFS_AUX, 32'h100, RSG_RESP_OKAY);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("irq", 32'h0, 32'(irq));
		// Toggled outputs and ended cycles leave flags; zeros keep them.
		rd(RSG_OFS_IRQ_FLAGS, 32'hC1, 32'hC1, RSG_RESP_OKAY);
		wr(RSG_OFS_IRQ_FLAGS, 32'h0, RSG_RESP_OKAY);
		rd(RSG_OFS_IRQ_FLAGS, 32'hC1, 32'hC1, RSG_RESP_OKAY);
		wr(RSG_OFS_IRQ_MASK, 32'h01, RSG_RESP_OKAY);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("irq", 32'h1, 32'(irq));
		wr(RSG_OFS_IRQ_FLAGS, 32'hFF, RSG_RESP_OKAY);
		rd(RSG_OFS_IRQ_FLAGS, 32'h0, 32'hC1, RSG_RESP_OKAY);
		@(negedge clock);
		chk("irq", 32'h0, 32'(irq));
		// Software capture of the frozen count, high byte kept aside.
		wr(RSG_OFS_CAPTURE, 32'h8000, RSG_RESP_OKAY);
		rd(RSG_OFS_CAPTURE, {16'h0, 4'h8, gen_count}, 32'h8FFF, 2'h0);
		rd(RSG_OFS_TEMP, {24'h0, 4'h8, gen_count[11:8]}, 32'hFF, 2'h0);
		// A three-sample pulse is swallowed; a steady level passes.
		wr(RSG_OFS_IN_A_CTRL, 32'hB0, RSG_RESP_OKAY);
		wr(RSG_OFS_IRQ_FLAGS, 32'hFF, RSG_RESP_OKAY);
		in_pin[0] <= 1'b1;
		repeat (3) @(posedge clock);
		in_pin[0] <= 1'b0;
		repeat (16) @(posedge clock);
		rd(RSG_OFS_IRQ_FLAGS, 32'h0, 32'h08, RSG_RESP_OKAY);
		in_pin[0] <= 1'b1;
		repeat (16) @(posedge clock);
		rd(RSG_OFS_IRQ_FLAGS, 32'h08, 32'h08, RSG_RESP_OKAY);
		// Every source of both blocks, with the polarity varied.
		for (n = 0; n < 8; n++) begin
			b4 = 4'(n);
			p = b4[1] ^ b4[2];
			idle(~p);
			wr(b4[2] ? RSG_OFS_IN_B_CTRL : RSG_OFS_IN_A_CTRL,
				{24'h0, 1'b1, b4[0], p, 5'h0}, RSG_RESP_OKAY);
			wr(RSG_OFS_OUT_CFG, {24'h0, b4[1] & ~b4[2], b4[1] & b4[2], 6'h0},
				RSG_RESP_OKAY);
			wr(RSG_OFS_IRQ_MASK, b4[2] ? 32'h10 : 32'h08, RSG_RESP_OKAY);
			repeat (8) @(posedge clock);
			wr(RSG_OFS_IRQ_FLAGS, 32'hFF, RSG_RESP_OKAY);
			drive(b4[1:0], int'(b4[2]), p);
			repeat (12) @(posedge clock);
			@(negedge clock);
			chk("irq", 32'h1, 32'(irq));
			rd(RSG_OFS_CAPTURE, {20'h0, gen_count}, 32'h8FFF, 2'h0);
			rd(RSG_OFS_IRQ_FLAGS, {27'h0, b4[2], ~b4[2], ramp_num, 1'b0},
				32'h1E, RSG_RESP_OKAY);
			wr(b4[2] ? RSG_OFS_IN_B_CTRL : RSG_OFS_IN_A_CTRL, 32'h0, 2'h0);
			wr(RSG_OFS_IRQ_FLAGS, 32'hFF, RSG_RESP_OKAY);
		end
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("irq", 32'h0, 32'(irq));
		// A live fault holds output A low while the generator runs.
		@(posedge clock);
		idle(1'b0);
		wr(RSG_OFS_OUT_CFG, 32'h0, RSG_RESP_OKAY);
		wr(RSG_OFS_IN_A_CTRL, 32'h24, RSG_RESP_OKAY);
		wr(RSG_OFS_GEN_CTRL, 32'h09, RSG_RESP_OKAY);
		in_pin[0] <= 1'b1;
		repeat (8) @(posedge clock);
		hi = 0;
		repeat (32) @(negedge clock) hi += int'(wave_out_a);
		chk("wave_out_a", 32'h0, 32'(hi));
		chk("fault_active", 32'h1, 32'(fault_active[0]));
		@(posedge clock);
		in_pin[0] <= 1'b0;
		repeat (8) @(posedge clock);
		repeat (32) @(negedge clock) hi += int'(wave_out_a);
		chk("wave_out_a", 32'h1, 32'(hi > 0));
		wr(RSG_OFS_GEN_CTRL, 32'h0, RSG_RESP_OKAY);
		finish_test();
	end
endmodule
`default_nettype wire
